// file: rtl/tocp_consts.svh
`ifndef TOCP_CONSTS_SVH
`define TOCP_CONSTS_SVH

// ==========================================================
// Reset and reload values
`define TOCP_CMP_RST        16'h8000
`define TOCP_CNT_RELOAD     16'hfffc

// ==========================================================
// Register byte addresses
`define TOCP_OFF_CTL1       12'h000
`define TOCP_OFF_CTL2       12'h004
`define TOCP_OFF_STATUS     12'h008
`define TOCP_OFF_CMP1_HI    12'h00c
`define TOCP_OFF_CMP1_LO    12'h010
`define TOCP_OFF_CMP2_HI    12'h014
`define TOCP_OFF_CMP2_LO    12'h018
`define TOCP_OFF_CNT_HI     12'h01c
`define TOCP_OFF_CNT_LO     12'h020
`define TOCP_OFF_CAP1_HI    12'h024
`define TOCP_OFF_CAP1_LO    12'h028
`define TOCP_OFF_CAP2_HI    12'h02c
`define TOCP_OFF_CAP2_LO    12'h030

// ==========================================================
// timer_control_one fields
`define TOCP_C1_CAP_IRQ_EN  7
`define TOCP_C1_CMP_IRQ_EN  6
`define TOCP_C1_FORCE2      4
`define TOCP_C1_FORCE1      3
`define TOCP_C1_LVL2        2
`define TOCP_C1_CAP_EDGE1   1
`define TOCP_C1_LVL1        0
`define TOCP_C1_FORCE_MASK  8'h18

// ==========================================================
// timer_control_two fields
`define TOCP_C2_PEN1        7
`define TOCP_C2_PEN2        6
`define TOCP_C2_PULSE       5
`define TOCP_C2_PWM         4
`define TOCP_C2_CLK_HI      3
`define TOCP_C2_CLK_LO      2
`define TOCP_C2_CAP_EDGE2   1
`define TOCP_C2_EXT_EDGE    0

// ==========================================================
// timer_status_register fields
`define TOCP_ST_IF1         7
`define TOCP_ST_CF1         6
`define TOCP_ST_IF2         4
`define TOCP_ST_CF2         3

// ==========================================================
// Clock select codes and prescaler terminal counts
`define TOCP_CLK_DIV4       2'h0
`define TOCP_CLK_DIV2       2'h1
`define TOCP_CLK_DIV8       2'h2
`define TOCP_CLK_EXT        2'h3
`define TOCP_DIV2_LAST      3'h1
`define TOCP_DIV4_LAST      3'h3
`define TOCP_DIV8_LAST      3'h7

`endif

// file: rtl/tocp_pkg.sv
`default_nettype none
package tocp_pkg;

    // ==========================================================
    // Operating modes
    typedef enum logic [1:0] {
        TOCP_MODE_COMPARE,
        TOCP_MODE_PULSE,
        TOCP_MODE_PWM
    } tocp_mode_t;

    // ==========================================================
    // Complete block state
    typedef struct packed {
        logic [7:0]  ctl1;
        logic [7:0]  ctl2;
        logic [15:0] cmp1;
        logic [15:0] cmp2;
        logic [15:0] sh1;
        logic [15:0] sh2;
        logic        lock1;
        logic        lock2;
        logic [15:0] cnt;
        logic [2:0]  div;
        logic        upd;
        logic        ext_q;
        logic        cin1_q;
        logic        cin2_q;
        logic [15:0] cap1;
        logic [15:0] cap2;
        logic        cf1;
        logic        cf2;
        logic        if1;
        logic        if2;
        logic        arm_cf1;
        logic        arm_cf2;
        logic        arm_if1;
        logic        arm_if2;
        logic        pin1;
        logic        pin2;
        logic [31:0] rdata;
    } tocp_state_t;

endpackage : tocp_pkg
`default_nettype wire

// file: rtl/tocp_top.sv
// The APB register port and the placing of the registers were left to the implementer.
`include "tocp_consts.svh"
`default_nettype none
module tocp_top (
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [11:0] i_paddr,
    input  wire logic [31:0] i_pwdata,
    output var  logic [31:0] o_prdata,
    output var  logic        o_pready,
    output var  logic        o_pslverr,
    input  wire logic        i_cap_in_one,
    input  wire logic        i_cap_in_two,
    input  wire logic        i_ext_clk,
    input  wire logic        i_cpu_int_mask,
    output var  logic        o_cmp_pin_one,
    output var  logic        o_cmp_pin_two,
    output var  logic        o_cmp_pin_en_one,
    output var  logic        o_cmp_pin_en_two,
    output var  logic        o_timer_irq
);

    // ==========================================================
    // State and reset image
    localparam tocp_pkg::tocp_state_t RST_STATE = '{
        cmp1    : `TOCP_CMP_RST,
        cmp2    : `TOCP_CMP_RST,
        sh1     : `TOCP_CMP_RST,
        sh2     : `TOCP_CMP_RST,
        cnt     : `TOCP_CNT_RELOAD,
        default : '0
    };

    tocp_pkg::tocp_state_t s_q;
    tocp_pkg::tocp_state_t s_d;

    // ==========================================================
    // Helpers
    function automatic logic hit_at(input logic [15:0] cnt, input logic [15:0] val,
                                    input logic div2);
        logic [15:0] eff;
        eff = div2 ? val : val + 16'h0001;
        return cnt == eff;
    endfunction : hit_at

    function automatic logic edge_of(input logic now, input logic prev, input logic rise);
        return rise ? (now & ~prev) : (~now & prev);
    endfunction : edge_of

    function automatic logic is_mapped(input logic [11:0] a);
        logic m;
        m = 1'b0;
        case (a)
            `TOCP_OFF_CTL1, `TOCP_OFF_CTL2, `TOCP_OFF_STATUS,
            `TOCP_OFF_CMP1_HI, `TOCP_OFF_CMP1_LO, `TOCP_OFF_CMP2_HI,
            `TOCP_OFF_CMP2_LO, `TOCP_OFF_CNT_HI, `TOCP_OFF_CNT_LO,
            `TOCP_OFF_CAP1_HI, `TOCP_OFF_CAP1_LO, `TOCP_OFF_CAP2_HI,
            `TOCP_OFF_CAP2_LO: m = 1'b1;
            default: m = 1'b0;
        endcase
        return m;
    endfunction : is_mapped

    // ==========================================================
    // Decode of mode, tick and events
    tocp_pkg::tocp_mode_t mode;
    logic [1:0]           clk_sel;
    logic [2:0]           div_last;
    logic                 div2;
    logic                 tick;
    logic                 ext_edge;
    logic                 c1_edge;
    logic                 c2_edge;
    logic                 m1;
    logic                 m2;
    logic                 is_pwm;
    logic                 is_pulse;
    logic                 acc;
    logic                 setup;
    logic                 wr;
    logic                 rd;

    assign is_pwm   = s_q.ctl2[`TOCP_C2_PWM];
    assign is_pulse = s_q.ctl2[`TOCP_C2_PULSE] & ~is_pwm;
    assign mode     = is_pwm ? tocp_pkg::TOCP_MODE_PWM :
                      is_pulse ? tocp_pkg::TOCP_MODE_PULSE : tocp_pkg::TOCP_MODE_COMPARE;
    assign clk_sel  = s_q.ctl2[`TOCP_C2_CLK_HI:`TOCP_C2_CLK_LO];
    assign div2     = clk_sel == `TOCP_CLK_DIV2;
    assign div_last = div2 ? `TOCP_DIV2_LAST :
                      (clk_sel == `TOCP_CLK_DIV4) ? `TOCP_DIV4_LAST : `TOCP_DIV8_LAST;
    assign ext_edge = edge_of(i_ext_clk, s_q.ext_q, s_q.ctl2[`TOCP_C2_EXT_EDGE]);
    assign tick     = (clk_sel == `TOCP_CLK_EXT) ? ext_edge : (s_q.div == div_last);
    assign c1_edge  = edge_of(i_cap_in_one, s_q.cin1_q, s_q.ctl1[`TOCP_C1_CAP_EDGE1]);
    assign c2_edge  = edge_of(i_cap_in_two, s_q.cin2_q, s_q.ctl2[`TOCP_C2_CAP_EDGE2]);

    // Matches look at the count just after it moved; PWM uses shadows and ignores locks
    assign m1 = s_q.upd & hit_at(s_q.cnt, is_pwm ? s_q.sh1 : s_q.cmp1, div2)
                & (is_pwm | ~s_q.lock1);
    assign m2 = s_q.upd & hit_at(s_q.cnt, is_pwm ? s_q.sh2 : s_q.cmp2, div2)
                & (is_pwm | ~s_q.lock2);

    assign setup = i_psel & ~i_penable;
    assign acc   = i_psel & i_penable;
    assign wr    = acc & i_pwrite;
    assign rd    = acc & ~i_pwrite;

    // ==========================================================
    // Next state
    always_comb begin
        s_d        = s_q;
        s_d.ext_q  = i_ext_clk;
        s_d.cin1_q = i_cap_in_one;
        s_d.cin2_q = i_cap_in_two;
        s_d.upd    = tick;
        // A count left over from a slower rate restarts instead of wrapping
        s_d.div    = (clk_sel == `TOCP_CLK_EXT || s_q.div >= div_last) ? 3'h0 :
                     s_q.div + 3'h1;

        // Read data is captured in the setup cycle so the access needs no wait state
        if (setup) begin
            case (i_paddr)
                `TOCP_OFF_CTL1:    s_d.rdata = {24'h000000, s_q.ctl1};
                `TOCP_OFF_CTL2:    s_d.rdata = {24'h000000, s_q.ctl2};
                `TOCP_OFF_STATUS:  s_d.rdata = {24'h000000, s_q.if1, s_q.cf1, 1'b0,
                                                s_q.if2, s_q.cf2, 3'h0};
                `TOCP_OFF_CMP1_HI: s_d.rdata = {24'h000000, s_q.cmp1[15:8]};
                `TOCP_OFF_CMP1_LO: s_d.rdata = {24'h000000, s_q.cmp1[7:0]};
                `TOCP_OFF_CMP2_HI: s_d.rdata = {24'h000000, s_q.cmp2[15:8]};
                `TOCP_OFF_CMP2_LO: s_d.rdata = {24'h000000, s_q.cmp2[7:0]};
                `TOCP_OFF_CNT_HI:  s_d.rdata = {24'h000000, s_q.cnt[15:8]};
                `TOCP_OFF_CNT_LO:  s_d.rdata = {24'h000000, s_q.cnt[7:0]};
                `TOCP_OFF_CAP1_HI: s_d.rdata = {24'h000000, s_q.cap1[15:8]};
                `TOCP_OFF_CAP1_LO: s_d.rdata = {24'h000000, s_q.cap1[7:0]};
                `TOCP_OFF_CAP2_HI: s_d.rdata = {24'h000000, s_q.cap2[15:8]};
                `TOCP_OFF_CAP2_LO: s_d.rdata = {24'h000000, s_q.cap2[7:0]};
                default:           s_d.rdata = 32'h00000000;
            endcase
        end

        // Status read arms the clear; a later low-byte access finishes it
        if (rd && i_paddr == `TOCP_OFF_STATUS) begin
            s_d.arm_cf1 = s_q.cf1;
            s_d.arm_cf2 = s_q.cf2;
            s_d.arm_if1 = s_q.if1;
            s_d.arm_if2 = s_q.if2;
        end
        if (acc && i_paddr == `TOCP_OFF_CMP1_LO && s_q.arm_cf1) begin
            s_d.cf1     = 1'b0;
            s_d.arm_cf1 = 1'b0;
        end
        if (acc && i_paddr == `TOCP_OFF_CMP2_LO && s_q.arm_cf2) begin
            s_d.cf2     = 1'b0;
            s_d.arm_cf2 = 1'b0;
        end
        if (acc && i_paddr == `TOCP_OFF_CAP1_LO && s_q.arm_if1) begin
            s_d.if1     = 1'b0;
            s_d.arm_if1 = 1'b0;
        end
        if (acc && i_paddr == `TOCP_OFF_CAP2_LO && s_q.arm_if2) begin
            s_d.if2     = 1'b0;
            s_d.arm_if2 = 1'b0;
        end

        // Register writes; hardware never touches the compare values
        if (wr) begin
            case (i_paddr)
                `TOCP_OFF_CTL1: begin
                    s_d.ctl1 = i_pwdata[7:0] & ~`TOCP_C1_FORCE_MASK;
                    if (!s_q.ctl2[`TOCP_C2_PULSE] && !is_pwm) begin
                        if (i_pwdata[`TOCP_C1_FORCE1] && s_q.ctl2[`TOCP_C2_PEN1]) begin
                            s_d.pin1 = i_pwdata[`TOCP_C1_LVL1];
                        end
                        if (i_pwdata[`TOCP_C1_FORCE2] && s_q.ctl2[`TOCP_C2_PEN2]) begin
                            s_d.pin2 = i_pwdata[`TOCP_C1_LVL2];
                        end
                    end
                end
                `TOCP_OFF_CTL2:    s_d.ctl2 = i_pwdata[7:0];
                `TOCP_OFF_CMP1_HI: begin
                    s_d.cmp1[15:8] = i_pwdata[7:0];
                    s_d.lock1      = 1'b1;
                end
                `TOCP_OFF_CMP1_LO: begin
                    s_d.cmp1[7:0] = i_pwdata[7:0];
                    s_d.lock1     = 1'b0;
                end
                `TOCP_OFF_CMP2_HI: begin
                    s_d.cmp2[15:8] = i_pwdata[7:0];
                    s_d.lock2      = 1'b1;
                end
                `TOCP_OFF_CMP2_LO: begin
                    s_d.cmp2[7:0] = i_pwdata[7:0];
                    s_d.lock2     = 1'b0;
                end
                default: ;
            endcase
        end

        // Counter: free running, FFFCh is the only reload
        if (tick) begin
            s_d.cnt = s_q.cnt + 16'h0001;
        end
        if (wr && i_paddr == `TOCP_OFF_CNT_LO) begin
            s_d.cnt = `TOCP_CNT_RELOAD;
        end

        // Capture two works in every mode
        if (c2_edge) begin
            s_d.cap2 = s_q.cnt;
            s_d.if2  = 1'b1;
        end

        // Hardware events come last so a set beats a clear in the same cycle
        case (mode)
            tocp_pkg::TOCP_MODE_COMPARE: begin
                s_d.sh1 = s_q.cmp1;
                s_d.sh2 = s_q.cmp2;
                if (c1_edge) begin
                    s_d.cap1 = s_q.cnt;
                    s_d.if1  = 1'b1;
                end
                if (m1) begin
                    s_d.cf1 = 1'b1;
                    if (s_q.ctl2[`TOCP_C2_PEN1]) begin
                        s_d.pin1 = s_q.ctl1[`TOCP_C1_LVL1];
                    end
                end
                if (m2) begin
                    s_d.cf2 = 1'b1;
                    if (s_q.ctl2[`TOCP_C2_PEN2]) begin
                        s_d.pin2 = s_q.ctl1[`TOCP_C1_LVL2];
                    end
                end
            end
            tocp_pkg::TOCP_MODE_PULSE: begin
                s_d.sh1 = s_q.cmp1;
                s_d.sh2 = s_q.cmp2;
                // No compare flag one here; compare two only times
                if (m1 && s_q.ctl2[`TOCP_C2_PEN1]) begin
                    s_d.pin1 = s_q.ctl1[`TOCP_C1_LVL1];
                end
                if (m2) begin
                    s_d.cf2 = 1'b1;
                end
                // Reload to FFFCh makes the pulse last compare value plus five ticks, or plus four at divide by two
                if (c1_edge) begin
                    s_d.cap1 = s_q.cnt;
                    s_d.cnt  = `TOCP_CNT_RELOAD;
                    s_d.if1  = 1'b1;
                    if (s_q.ctl2[`TOCP_C2_PEN1]) begin
                        s_d.pin1 = s_q.ctl1[`TOCP_C1_LVL2];
                    end
                end
            end
            tocp_pkg::TOCP_MODE_PWM: begin
                // Capture one is cut off; compare flags are never set
                if (m1 && s_q.ctl2[`TOCP_C2_PEN1]) begin
                    s_d.pin1 = s_q.ctl1[`TOCP_C1_LVL1];
                end
                if (m2) begin
                    s_d.cnt = `TOCP_CNT_RELOAD;
                    s_d.if1 = 1'b1;
                    if (s_q.ctl2[`TOCP_C2_PEN1]) begin
                        s_d.pin1 = s_q.ctl1[`TOCP_C1_LVL2];
                    end
                    // Half-written values stay out of the shadow to avoid spikes
                    if (!s_q.lock1) begin
                        s_d.sh1 = s_q.cmp1;
                    end
                    if (!s_q.lock2) begin
                        s_d.sh2 = s_q.cmp2;
                    end
                end
            end
            default: ;
        endcase
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            s_q <= RST_STATE;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // Outputs
    assign o_prdata         = s_q.rdata;
    assign o_pready         = i_penable;
    assign o_pslverr        = acc & ~is_mapped(i_paddr);
    assign o_cmp_pin_one    = s_q.pin1;
    assign o_cmp_pin_two    = s_q.pin2;
    assign o_cmp_pin_en_one = s_q.ctl2[`TOCP_C2_PEN1];
    assign o_cmp_pin_en_two = s_q.ctl2[`TOCP_C2_PEN2] & ~is_pulse & ~is_pwm;
    assign o_timer_irq      = ~i_cpu_int_mask &
                              ((s_q.ctl1[`TOCP_C1_CMP_IRQ_EN] & (s_q.cf1 | s_q.cf2)) |
                               (s_q.ctl1[`TOCP_C1_CAP_IRQ_EN] & (s_q.if1 | s_q.if2)));

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    cmp_hold_a: assert property (!(wr && (i_paddr == `TOCP_OFF_CMP1_HI ||
        i_paddr == `TOCP_OFF_CMP1_LO)) |=> $stable(s_q.cmp1))
        else $error("compare value one changed without a write");
    pin_level_a: assert property (mode == tocp_pkg::TOCP_MODE_COMPARE && m1 &&
        s_q.ctl2[`TOCP_C2_PEN1] && !wr |=> o_cmp_pin_one == $past(s_q.ctl1[`TOCP_C1_LVL1]))
        else $error("pin one did not take match level");
    flag_irq_a: assert property (mode == tocp_pkg::TOCP_MODE_COMPARE && m2 &&
        s_q.ctl1[`TOCP_C1_CMP_IRQ_EN] && !i_cpu_int_mask ##1 !i_cpu_int_mask
        |-> s_q.cf2 && o_timer_irq)
        else $error("compare two match gave no flag or irq");
    lock_hold_a: assert property (s_q.lock1 && !is_pwm && !s_q.cf1 &&
        !(wr && i_paddr == `TOCP_OFF_CMP1_LO) |=> !s_q.cf1)
        else $error("locked channel one set its flag");
    pen_off_a: assert property (!s_q.ctl2[`TOCP_C2_PEN1] |=> $stable(o_cmp_pin_one))
        else $error("disabled pin one changed");
    force_off_a: assert property (wr && i_paddr == `TOCP_OFF_CTL1 && (is_pwm || is_pulse)
        && !m1 && !m2 && !c1_edge |=> $stable(o_cmp_pin_one))
        else $error("force acted in pulse or pwm mode");
    pulse_trig_a: assert property (is_pulse && c1_edge && s_q.ctl2[`TOCP_C2_PEN1] |=>
        s_q.cnt == `TOCP_CNT_RELOAD && s_q.if1 &&
        o_cmp_pin_one == $past(s_q.ctl1[`TOCP_C1_LVL2]))
        else $error("pulse trigger misbehaved");
    pulse_nocf1_a: assert property (is_pulse && !s_q.cf1 |=> !s_q.cf1)
        else $error("compare flag one set in pulse mode");
    pwm_period_a: assert property (is_pwm && m2 |=> s_q.cnt == `TOCP_CNT_RELOAD &&
        !$rose(s_q.cf2))
        else $error("pwm period end wrong");
    div2_tick_a: assert property (div2 && tick && !wr |=> !tick ##1 tick)
        else $error("divide by two tick spacing wrong");

    match_c:   cover property (mode == tocp_pkg::TOCP_MODE_COMPARE && m1);
    pulse_c:   cover property (is_pulse && c1_edge ##[1:300] m1);
    pwm_c:     cover property (is_pwm && m1 ##[1:300] m2);
    flagclr_c: cover property (s_q.cf1 ##1 !s_q.cf1);

endmodule : tocp_top
`default_nettype wire

// file: testbench/timer_output_compare_opm_pwm_tb_top.sv
`include "tocp_consts.svh"
`default_nettype none
module timer_output_compare_opm_pwm_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr, e;
    logic        cap1, cap2, ext_clk, int_mask, pin1, pin2, pen1, pen2, irq, fire, fire2;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [7:0]  hlen;
    int          failures, n_tests;
    tocp_top u_dut (.i_mclk(mclk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_cap_in_one(cap1), .i_cap_in_two(cap2),
        .i_ext_clk(ext_clk), .i_cpu_int_mask(int_mask), .o_cmp_pin_one(pin1),
        .o_cmp_pin_two(pin2), .o_cmp_pin_en_one(pen1), .o_cmp_pin_en_two(pen2),
        .o_timer_irq(irq));
    tocp_pin_model u_pins (.i_mclk(mclk), .i_fire(fire), .i_fire_two(fire2),
        .i_pin_one(pin1), .o_cap_in_one(cap1), .o_cap_in_two(cap2), .o_ext_clk(ext_clk),
        .o_high_len(hlen));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ==========================================================
    // Shared tasks
    task print_verdict;
        $display("Checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : print_verdict
    task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task hang(input string nm);
        failures++;
        $display("Error %s expected done seen timeout", nm);
        print_verdict();
    endtask : hang
    // Starts after a rising edge, returns at the edge that took the answer
    task apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int k;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        for (k = 0; k < 16; k++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        if (k == 16) hang("pready");
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Samples on the falling edge, away from register updates
    task wait_pin(input logic v, input int n);
        int k;
        for (k = 0; k < n; k++) begin
            @(negedge mclk);
            if (pin1 === v) break;
        end
        if (k == n) hang("pin1");
    endtask : wait_pin
    // ==========================================================
    // Scenarios
    task t_reset;
        apb(0, `TOCP_OFF_CNT_HI, 0);
        chk("cnt_hi", r, 32'hff);
        apb(0, `TOCP_OFF_CMP1_HI, 0);
        chk("cmp1_hi", r, 32'h80);
        apb(0, `TOCP_OFF_CMP2_LO, 0);
        chk("cmp2_lo", r, 32'h00);
        apb(0, 12'h040, 0);
        chk("slverr", 32'(e), 32'h1);
    endtask : t_reset
    task t_compare;
        apb(1, `TOCP_OFF_CTL1, 8'h41);
        apb(1, `TOCP_OFF_CTL2, 8'h84);
        apb(1, `TOCP_OFF_CMP1_HI, 8'h00);
        apb(1, `TOCP_OFF_CMP1_LO, 8'h20);
        apb(1, `TOCP_OFF_CNT_LO, 8'h00);
        wait_pin(1'b1, 300);
        chk("irq", 32'(irq), 32'h1);
        apb(0, `TOCP_OFF_STATUS, 0);
        chk("flag1", r & 32'h48, 32'h40);
        int_mask <= 1'b1;
        @(negedge mclk);
        chk("irq_masked", 32'(irq), 32'h0);
        @(posedge mclk);
        int_mask <= 1'b0;
        apb(1, `TOCP_OFF_CMP1_LO, 8'h20);
        apb(0, `TOCP_OFF_STATUS, 0);
        chk("flag1_clr", r & 32'h48, 32'h00);
        apb(1, `TOCP_OFF_CTL1, 8'h40);
        apb(1, `TOCP_OFF_CMP1_HI, 8'h00);
        apb(1, `TOCP_OFF_CNT_LO, 8'h00);
        repeat (150) @(negedge mclk);
        chk("locked", 32'(pin1), 32'h1);
        apb(1, `TOCP_OFF_CTL2, 8'h80);
        apb(1, `TOCP_OFF_CMP1_LO, 8'h20);
        apb(1, `TOCP_OFF_CNT_LO, 8'h00);
        wait_pin(1'b0, 300);
        // Divide by four matches one count late, so the count reads value plus one
        apb(0, `TOCP_OFF_CNT_LO, 0);
        chk("match_div4", r, 32'h21);
    endtask : t_compare
    task t_force;
        apb(0, `TOCP_OFF_STATUS, 0);
        apb(1, `TOCP_OFF_CMP1_LO, 8'h20);
        apb(1, `TOCP_OFF_CTL1, 8'h49);
        @(negedge mclk);
        chk("forced", 32'(pin1), 32'h1);
        chk("force_irq", 32'(irq), 32'h0);
        apb(0, `TOCP_OFF_STATUS, 0);
        chk("force_flag", r & 32'h40, 32'h00);
        apb(1, `TOCP_OFF_CTL2, 8'ha4);
        apb(1, `TOCP_OFF_CTL1, 8'h08);
        @(negedge mclk);
        chk("force_pulse", 32'(pin1), 32'h1);
        apb(1, `TOCP_OFF_CTL2, 8'h84);
        apb(1, `TOCP_OFF_CTL1, 8'h08);
        @(negedge mclk);
        chk("force_low", 32'(pin1), 32'h0);
        apb(1, `TOCP_OFF_CTL2, 8'hc4);
        apb(1, `TOCP_OFF_CTL1, 8'h14);
        @(negedge mclk);
        chk("force2", 32'(pin2), 32'h1);
        chk("pen_one", 32'(pen1), 32'h1);
        chk("pen_two", 32'(pen2), 32'h1);
        apb(1, `TOCP_OFF_CTL2, 8'he4);
        @(negedge mclk);
        chk("pen_two_pulse", 32'(pen2), 32'h0);
    endtask : t_force
    task t_pulse;
        apb(1, `TOCP_OFF_CMP1_HI, 8'h00);
        apb(1, `TOCP_OFF_CMP1_LO, 8'h04);
        apb(1, `TOCP_OFF_CTL1, 8'h86);
        apb(1, `TOCP_OFF_CTL2, 8'ha6);
        fire  <= 1'b1;
        fire2 <= 1'b1;
        @(posedge mclk);
        fire  <= 1'b0;
        fire2 <= 1'b0;
        wait_pin(1'b1, 50);
        chk("cap_irq", 32'(irq), 32'h1);
        wait_pin(1'b0, 100);
        repeat (2) @(negedge mclk);
        // Width is (4 + 4) ticks of two clocks; edge detection may add slack
        chk("width", 32'(hlen >= 8'd14 && hlen <= 8'd22), 32'h1);
        apb(0, `TOCP_OFF_STATUS, 0);
        chk("pulse_st", r & 32'hd0, 32'h90);
    endtask : t_pulse
    task t_pwm;
        apb(1, `TOCP_OFF_CTL1, 8'h04);
        apb(1, `TOCP_OFF_CMP2_HI, 8'h00);
        apb(1, `TOCP_OFF_CMP2_LO, 8'h10);
        apb(1, `TOCP_OFF_CMP1_LO, 8'h08);
        apb(1, `TOCP_OFF_CTL2, 8'hb4);
        apb(1, `TOCP_OFF_CNT_LO, 8'h00);
        wait_pin(1'b1, 100);
        wait_pin(1'b0, 100);
        wait_pin(1'b1, 100);
        apb(0, `TOCP_OFF_STATUS, 0);
        chk("pwm_flags", r & 32'h48, 32'h00);
    endtask : t_pwm
    task t_cmp2;
        apb(1, `TOCP_OFF_CTL2, 8'h44);
        apb(1, `TOCP_OFF_CTL1, 8'h40);
        apb(1, `TOCP_OFF_CNT_LO, 8'h00);
        repeat (60) @(negedge mclk);
        chk("pin2_match", 32'(pin2), 32'h0);
        chk("irq2", 32'(irq), 32'h1);
        apb(0, `TOCP_OFF_STATUS, 0);
        chk("flag2", r & 32'h08, 32'h08);
    endtask : t_cmp2
    // ==========================================================
    // Main sequence
    initial begin
        failures = 0;
        n_tests  = 0;
        rst_n    = 1'b0;
        psel     = 1'b0;
        penable  = 1'b0;
        pwrite   = 1'b0;
        paddr    = 12'h000;
        pwdata   = 32'h0;
        int_mask = 1'b0;
        fire     = 1'b0;
        fire2    = 1'b0;
        repeat (8) @(posedge mclk);
        chk("pin_rst", 32'(pin1), 32'h0);
        rst_n <= 1'b1;
        t_reset();
        t_compare();
        t_force();
        t_pulse();
        t_pwm();
        t_cmp2();
        print_verdict();
    end
endmodule : timer_output_compare_opm_pwm_tb_top
`default_nettype wire

// file: testbench/tocp_pin_model.sv
`default_nettype none
module tocp_pin_model (
    input  wire logic       i_mclk,
    input  wire logic       i_fire,
    input  wire logic       i_fire_two,
    input  wire logic       i_pin_one,
    output var  logic       o_cap_in_one,
    output var  logic       o_cap_in_two,
    output var  logic       o_ext_clk,
    output var  logic [7:0] o_high_len
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] run_q;
    initial begin
        o_cap_in_one = 1'b0;
        o_cap_in_two = 1'b0;
        o_ext_clk    = 1'b0;
        o_high_len   = 8'h00;
        run_q        = 8'h00;
    end
    // ==========================================================
    // Event source and pin load
    always @(posedge i_mclk) begin
        o_cap_in_one <= i_fire;
        o_cap_in_two <= i_fire_two;
        // Ticks come from the divider here, so the external line stands still
        o_ext_clk    <= 1'b0;
        run_q        <= i_pin_one ? run_q + 8'h01 : 8'h00;
        if (!i_pin_one && run_q != 8'h00) begin
            o_high_len <= run_q;
        end
    end
endmodule : tocp_pin_model
`default_nettype wire
